// >>> src/rsm_pkg.sv
// Shared constants, register map and line-setting decode for the sensor register map
package rsm_pkg;

  // ==========================================================================
  // Function and exception codes
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // ==========================================================================
  // Configuration and information addresses (wire addresses)
  localparam logic [15:0] ADDR_NODE = 16'h0000;
  localparam logic [15:0] ADDR_LINE = 16'h0001;
  localparam logic [15:0] ADDR_SERIAL = 16'h0000;
  localparam logic [15:0] SERIAL_WORDS = 16'h0008;
  localparam logic [15:0] ADDR_FIRMWARE = 16'h0008;
  localparam logic [15:0] ADDR_NAME = 16'h0009;
  localparam logic [15:0] REGNUM_BASE = 16'h0001;

  // ==========================================================================
  // Node address and line settings
  localparam logic [7:0] NODE_RESET = 8'hed;
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'hf7;
  localparam int LINE_W = 5;
  localparam int LINE_BAUD_LSB = 0;
  localparam int LINE_PAR_LSB = 2;
  localparam int LINE_STOP_BIT = 4;
  localparam logic [1:0] BAUD_9600 = 2'h0;
  localparam logic [1:0] BAUD_19200 = 2'h1;
  localparam logic [1:0] BAUD_38400 = 2'h2;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic STOP_ONE = 1'b0;
  localparam logic STOP_TWO = 1'b1;
  localparam logic [4:0] LINE_RESET = {STOP_ONE, PAR_EVEN, BAUD_9600};
  localparam int DATA_BITS = 8;

  // ==========================================================================
  // Second protocol: fixed 8N1, six baud codes 9600..115200
  localparam logic [6:0] BAC_ADDR_RESET = 7'h06;
  localparam logic [2:0] BAC_BAUD_9600 = 3'h0;
  localparam logic [2:0] BAC_BAUD_38400 = 3'h2;
  localparam logic [2:0] BAC_BAUD_115200 = 3'h5;
  localparam logic [1:0] BAC_PARITY = PAR_NONE;
  localparam logic BAC_STOP = STOP_ONE;

  // ==========================================================================
  // Measured quantities
  localparam int NQ = 11;
  localparam logic [1:0] AV_ALWAYS = 2'h0;
  localparam logic [1:0] AV_FULL = 2'h1;
  localparam logic [1:0] AV_UNHEATED = 2'h2;
  // Order: gas avg, gas raw, p mbar, p psi, humidity, T C, T F, T K, dew C, dew F, dew K
  localparam logic [15:0] FLOAT_ADDR [NQ] = '{16'h0424, 16'h0426, 16'h04b0, 16'h04b2, 16'h03fc,
    16'h03ea, 16'h03ec, 16'h03f0, 16'h0450, 16'h0452, 16'h047a};
  localparam logic [15:0] INT_ADDR [NQ] = '{16'h0fbe, 16'h0fbf, 16'h1004, 16'h1005, 16'h0faa,
    16'h0fa1, 16'h0fa2, 16'h0fa4, 16'h0fd4, 16'h0fd5, 16'h0fe9};
  localparam int INT_SCALE [NQ] = '{1, 1, 10, 100, 100, 100, 50, 50, 100, 100, 100};
  localparam logic [1:0] AVAIL [NQ] = '{AV_ALWAYS, AV_ALWAYS, AV_FULL, AV_FULL, AV_UNHEATED,
    AV_UNHEATED, AV_UNHEATED, AV_UNHEATED, AV_FULL, AV_FULL, AV_FULL};
  localparam int CENTI = 100;

  // ==========================================================================
  // Controller command registers
  localparam logic [7:0] CMD_NODE = 8'h00;
  localparam logic [7:0] CMD_FUNC = 8'h01;
  localparam logic [7:0] CMD_REGNUM = 8'h02;
  localparam logic [7:0] CMD_WDATA = 8'h03;
  localparam logic [7:0] CMD_CTRL = 8'h04;
  localparam logic [7:0] CMD_STATUS = 8'h05;
  localparam logic [7:0] CMD_RDATA = 8'h06;
  localparam logic [7:0] CMD_LINE = 8'h07;
  localparam logic [7:0] CMD_BACBAUD = 8'h08;
  localparam int CTRL_START = 0;
  localparam int CTRL_BACNET = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_EXC = 2;
  localparam int ST_TIMEOUT = 3;
  localparam int ST_CODE_LSB = 8;
  localparam logic [7:0] RSP_TIMEOUT_CYC = 8'h10;

  // Shared check of a line-settings word
  function automatic logic line_ok(input logic [4:0] v);
    return (v[LINE_BAUD_LSB +: 2] <= BAUD_38400) && (v[LINE_PAR_LSB +: 2] <= PAR_EVEN);
  endfunction

endpackage

// >>> src/rsm_link_if.sv
// Transaction-level link between the bus master and the sensor register map
`timescale 1ns/1ps
interface rsm_link_if;
  logic req_valid;
  logic req_bacnet;
  logic [7:0] req_node;
  logic [7:0] req_func;
  logic [15:0] req_addr;
  logic [15:0] req_data;
  logic rsp_valid;
  logic rsp_exc;
  logic [7:0] rsp_code;
  logic [15:0] rsp_data;

  modport device (
    input req_valid, req_bacnet, req_node, req_func, req_addr, req_data,
    output rsp_valid, rsp_exc, rsp_code, rsp_data
  );

  modport master (
    output req_valid, req_bacnet, req_node, req_func, req_addr, req_data,
    input rsp_valid, rsp_exc, rsp_code, rsp_data
  );
endinterface

// >>> src/rsm_device.sv
// Sensor end: configuration registers, information words and measurement register map
//
// Functional notes
// - Line: 9600/19200/38400, 8 bits, parity choice, stop
// - Address 0x00 node, 0x01 line settings
// - Configuration read 0x03, written 0x06
// - Measurements readable by 0x03 or 0x04 alike
// - Wire address is register number minus one
// - Serial number: eight ASCII words
// - Firmware word: major high, minor low
// - Sensor name word follows firmware
// - Each quantity as float and integer
// - Integer holds value times listed scale
// - Humidity, temperature: full variant, unheated only
// - Dew point valid on full variant always
// - Second-protocol settings via vendor path or link
// - Master shared-net default 9600 8E1
// - Second-protocol shared-net default 38400 8N1
// - Float: low word first, sign word second
`timescale 1ns/1ps
module rsm_device #(
  parameter logic [127:0] SERIAL_ASCII = 128'h30303030_30303030_30303030_30303031,
  // Arbitrary neutral values
  parameter logic [7:0] FW_MAJOR = 8'h01,
  parameter logic [7:0] FW_MINOR = 8'h00,
  parameter logic [15:0] SENSOR_NAME = 16'h0001,
  parameter logic [1:0] BAUD_RESET = rsm_pkg::BAUD_9600,
  parameter logic [2:0] BAC_BAUD_RESET = rsm_pkg::BAC_BAUD_38400
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link
  rsm_link_if.device lk,
  // Measurements: IEEE754 floats and signed hundredths of the unit
  input wire logic [31:0] meas_float [rsm_pkg::NQ],
  input wire logic [31:0] meas_centi [rsm_pkg::NQ],
  // Variant and heating state
  input wire logic full_sensor_variant,
  input wire logic heating_on,
  // Vendor configuration path
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_sel,
  input wire logic [15:0] cfg_data,
  // Current settings
  output logic [7:0] bus_node_number,
  output logic [1:0] line_baud,
  output logic [1:0] line_parity,
  output logic line_stop,
  output logic [6:0] bac_node,
  output logic [2:0] bac_baud,
  output logic [1:0] bac_parity,
  output logic bac_stop
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0] node;
    logic [4:0] line;
    logic [6:0] bac_addr;
    logic [2:0] bac_baud;
    logic rsp_valid;
    logic rsp_exc;
    logic [7:0] rsp_code;
    logic [15:0] rsp_data;
  } rsm_dev_state_t;

  localparam rsm_dev_state_t RESET_STATE = '{
    node: rsm_pkg::NODE_RESET,
    line: {rsm_pkg::STOP_ONE, rsm_pkg::PAR_EVEN, BAUD_RESET},
    bac_addr: rsm_pkg::BAC_ADDR_RESET,
    bac_baud: BAC_BAUD_RESET,
    rsp_valid: 1'b0,
    rsp_exc: 1'b0,
    rsp_code: 8'h00,
    rsp_data: 16'h0000
  };

  rsm_dev_state_t s_reg;
  rsm_dev_state_t s_next;

  // ==========================================================================
  // Helpers
  // Hundredths to scaled signed 16 bits, saturating instead of wrapping
  function automatic logic [15:0] to_int(input logic [31:0] centi, input int scale);
    logic signed [47:0] p;
    logic signed [47:0] q;
    p = 48'($signed(centi)) * 48'(scale);
    q = p / 48'(rsm_pkg::CENTI);
    if (q > 48'sh0000_0000_7fff)
      return 16'h7fff;
    else if (q < $signed(48'hffff_ffff_8000))
      return 16'h8000;
    else
      return q[15:0];
  endfunction

  function automatic logic node_ok(input logic [15:0] v);
    return (v >= 16'(rsm_pkg::NODE_MIN)) && (v <= 16'(rsm_pkg::NODE_MAX));
  endfunction

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic hit;
    logic avail;
    logic [15:0] word;
    logic addressed;
    hit = 1'b0;
    avail = 1'b0;
    word = 16'h0000;
    addressed = 1'b0;
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;

    // Vendor path; a same-cycle link write overrides below
    if (cfg_wr)
    begin
      case (cfg_sel)
        2'h0: if (node_ok(cfg_data)) s_next.node = cfg_data[7:0];
        2'h1: if (rsm_pkg::line_ok(cfg_data[4:0]) && cfg_data[15:5] == 11'h000) s_next.line = cfg_data[4:0];
        2'h2: if (cfg_data[15:7] == 9'h000) s_next.bac_addr = cfg_data[6:0];
        2'h3: if (cfg_data <= 16'(rsm_pkg::BAC_BAUD_115200)) s_next.bac_baud = cfg_data[2:0];
        default: ;
      endcase
    end

    // Only own address is answered, others stay silent
    if (lk.req_bacnet)
      addressed = (lk.req_node == {1'b0, s_reg.bac_addr});
    else
      addressed = (lk.req_node == s_reg.node);

    // Measurement and information lookup
    for (int q = 0; q < rsm_pkg::NQ; q++)
    begin
      case (rsm_pkg::AVAIL[q])
        rsm_pkg::AV_FULL: avail = full_sensor_variant;
        rsm_pkg::AV_UNHEATED: avail = full_sensor_variant && !heating_on;
        default: avail = 1'b1;
      endcase
      if (lk.req_addr == rsm_pkg::FLOAT_ADDR[q])
      begin
        hit = avail;
        word = meas_float[q][15:0];
      end
      if (lk.req_addr == rsm_pkg::FLOAT_ADDR[q] + 16'h0001)
      begin
        hit = avail;
        word = meas_float[q][31:16];
      end
      if (lk.req_addr == rsm_pkg::INT_ADDR[q])
      begin
        hit = avail;
        word = to_int(meas_centi[q], rsm_pkg::INT_SCALE[q]);
      end
    end
    if (lk.req_addr < rsm_pkg::ADDR_SERIAL + rsm_pkg::SERIAL_WORDS)
    begin
      hit = 1'b1;
      word = SERIAL_ASCII[7'(7'd112 - {lk.req_addr[2:0], 4'h0}) +: 16];
    end
    if (lk.req_addr == rsm_pkg::ADDR_FIRMWARE)
    begin
      hit = 1'b1;
      word = {FW_MAJOR, FW_MINOR};
    end
    if (lk.req_addr == rsm_pkg::ADDR_NAME)
    begin
      hit = 1'b1;
      word = SENSOR_NAME;
    end

    if (lk.req_valid && addressed)
    begin
      s_next.rsp_valid = 1'b1;
      s_next.rsp_exc = 1'b0;
      s_next.rsp_code = lk.req_func;
      s_next.rsp_data = 16'h0000;
      case (lk.req_func)
        rsm_pkg::FC_WRITE_SINGLE:
        begin
          s_next.rsp_data = lk.req_data;
          if (lk.req_addr == rsm_pkg::ADDR_NODE)
          begin
            if (lk.req_bacnet && lk.req_data[15:7] == 9'h000)
              s_next.bac_addr = lk.req_data[6:0];
            else if (!lk.req_bacnet && node_ok(lk.req_data))
              s_next.node = lk.req_data[7:0];
            else
            begin
              s_next.rsp_exc = 1'b1;
              s_next.rsp_code = rsm_pkg::EXC_VALUE;
            end
          end
          else if (lk.req_addr == rsm_pkg::ADDR_LINE)
          begin
            if (lk.req_bacnet && lk.req_data <= 16'(rsm_pkg::BAC_BAUD_115200))
              s_next.bac_baud = lk.req_data[2:0];
            else if (!lk.req_bacnet && rsm_pkg::line_ok(lk.req_data[4:0]) && lk.req_data[15:5] == 11'h000)
              s_next.line = lk.req_data[4:0];
            else
            begin
              s_next.rsp_exc = 1'b1;
              s_next.rsp_code = rsm_pkg::EXC_VALUE;
            end
          end
          else
          begin
            s_next.rsp_exc = 1'b1;
            s_next.rsp_code = rsm_pkg::EXC_ADDR;
          end
        end
        rsm_pkg::FC_READ_HOLD, rsm_pkg::FC_READ_INPUT:
        begin
          // Holding space shadows serial words 0 and 1 for 0x03 only
          if (lk.req_func == rsm_pkg::FC_READ_HOLD && lk.req_addr == rsm_pkg::ADDR_NODE)
            s_next.rsp_data = lk.req_bacnet ? {9'h000, s_reg.bac_addr} : {8'h00, s_reg.node};
          else if (lk.req_func == rsm_pkg::FC_READ_HOLD && lk.req_addr == rsm_pkg::ADDR_LINE)
            s_next.rsp_data = lk.req_bacnet ? {13'h0000, s_reg.bac_baud} : {11'h000, s_reg.line};
          else if (hit)
            s_next.rsp_data = word;
          else
          begin
            s_next.rsp_exc = 1'b1;
            s_next.rsp_code = rsm_pkg::EXC_ADDR;
          end
        end
        default:
        begin
          s_next.rsp_exc = 1'b1;
          s_next.rsp_code = rsm_pkg::EXC_FUNC;
        end
      endcase
      if (s_next.rsp_exc) s_next.rsp_data = 16'h0000;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_reg <= RESET_STATE;
    else
      s_reg <= s_next;
  end

  // ==========================================================================
  // Outputs
  assign lk.rsp_valid = s_reg.rsp_valid;
  assign lk.rsp_exc = s_reg.rsp_exc;
  assign lk.rsp_code = s_reg.rsp_code;
  assign lk.rsp_data = s_reg.rsp_data;
  assign bus_node_number = s_reg.node;
  assign line_baud = s_reg.line[rsm_pkg::LINE_BAUD_LSB +: 2];
  assign line_parity = s_reg.line[rsm_pkg::LINE_PAR_LSB +: 2];
  assign line_stop = s_reg.line[rsm_pkg::LINE_STOP_BIT];
  assign bac_node = s_reg.bac_addr;
  assign bac_baud = s_reg.bac_baud;
  // Second protocol framing never changes
  assign bac_parity = rsm_pkg::BAC_PARITY;
  assign bac_stop = rsm_pkg::BAC_STOP;

endmodule // rsm_device

// >>> src/rsm_master.sv
// Bus master end: command registers drive one single-register transaction at a time
`timescale 1ns/1ps
module rsm_master (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Software port
  input wire logic [7:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Link
  rsm_link_if.master lk,
  // Own line settings
  output logic [1:0] line_baud,
  output logic [1:0] line_parity,
  output logic line_stop,
  output logic [2:0] bac_baud
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {RSM_IDLE, RSM_WAIT} rsm_mst_phase_t;

  typedef struct packed {
    rsm_mst_phase_t phase;
    logic [7:0] node;
    logic [7:0] func;
    logic [15:0] regnum;
    logic [15:0] wdata;
    logic bacnet;
    logic [15:0] waddr;
    logic req_valid;
    logic done;
    logic exc;
    logic timeout;
    logic [7:0] code;
    logic [15:0] rdata;
    logic [7:0] cnt;
    logic [4:0] line;
    logic [2:0] bac_baud;
    logic [15:0] sw_rdata;
  } rsm_mst_state_t;

  localparam rsm_mst_state_t RESET_STATE = '{
    phase: RSM_IDLE, node: rsm_pkg::NODE_RESET, func: rsm_pkg::FC_READ_HOLD, regnum: rsm_pkg::REGNUM_BASE,
    wdata: 16'h0000, bacnet: 1'b0, waddr: 16'h0000, req_valid: 1'b0, done: 1'b0, exc: 1'b0,
    timeout: 1'b0, code: 8'h00, rdata: 16'h0000, cnt: 8'h00,
    line: rsm_pkg::LINE_RESET, bac_baud: rsm_pkg::BAC_BAUD_38400, sw_rdata: 16'h0000
  };

  rsm_mst_state_t s_reg;
  rsm_mst_state_t s_next;

  // ==========================================================================
  // Next state
  always_comb
  begin
    s_next = s_reg;
    s_next.req_valid = 1'b0;
    s_next.sw_rdata = 16'h0000;

    if (sw_wr)
    begin
      case (sw_addr)
        rsm_pkg::CMD_NODE: s_next.node = sw_wdata[7:0];
        rsm_pkg::CMD_FUNC: s_next.func = sw_wdata[7:0];
        rsm_pkg::CMD_REGNUM: s_next.regnum = sw_wdata;
        rsm_pkg::CMD_WDATA: s_next.wdata = sw_wdata;
        rsm_pkg::CMD_LINE: if (rsm_pkg::line_ok(sw_wdata[4:0])) s_next.line = sw_wdata[4:0];
        rsm_pkg::CMD_BACBAUD: if (sw_wdata <= 16'(rsm_pkg::BAC_BAUD_115200)) s_next.bac_baud = sw_wdata[2:0];
        rsm_pkg::CMD_CTRL:
        begin
          // A start while busy is dropped
          if (sw_wdata[rsm_pkg::CTRL_START] && s_reg.phase == RSM_IDLE)
          begin
            s_next.phase = RSM_WAIT;
            s_next.bacnet = sw_wdata[rsm_pkg::CTRL_BACNET];
            s_next.waddr = s_reg.regnum - rsm_pkg::REGNUM_BASE;
            s_next.req_valid = 1'b1;
            s_next.cnt = 8'h00;
            s_next.done = 1'b0;
            s_next.exc = 1'b0;
            s_next.timeout = 1'b0;
          end
        end
        default: ;
      endcase
    end

    case (s_reg.phase)
      RSM_WAIT:
      begin
        s_next.cnt = s_reg.cnt + 8'h01;
        if (lk.rsp_valid)
        begin
          s_next.phase = RSM_IDLE;
          s_next.done = 1'b1;
          s_next.exc = lk.rsp_exc;
          s_next.code = lk.rsp_code;
          s_next.rdata = lk.rsp_data;
        end
        // Unaddressed or ignored requests never answer
        else if (s_reg.cnt == rsm_pkg::RSP_TIMEOUT_CYC)
        begin
          s_next.phase = RSM_IDLE;
          s_next.timeout = 1'b1;
        end
      end
      default: ;
    endcase

    if (sw_rd)
    begin
      case (sw_addr)
        rsm_pkg::CMD_NODE: s_next.sw_rdata = {8'h00, s_reg.node};
        rsm_pkg::CMD_FUNC: s_next.sw_rdata = {8'h00, s_reg.func};
        rsm_pkg::CMD_REGNUM: s_next.sw_rdata = s_reg.regnum;
        rsm_pkg::CMD_WDATA: s_next.sw_rdata = s_reg.wdata;
        rsm_pkg::CMD_CTRL: s_next.sw_rdata = {14'h0000, s_reg.bacnet, 1'b0};
        rsm_pkg::CMD_STATUS: s_next.sw_rdata = {s_reg.code, 4'h0, s_reg.timeout, s_reg.exc, s_reg.done,
          s_reg.phase == RSM_WAIT};
        rsm_pkg::CMD_RDATA: s_next.sw_rdata = s_reg.rdata;
        rsm_pkg::CMD_LINE: s_next.sw_rdata = {11'h000, s_reg.line};
        rsm_pkg::CMD_BACBAUD: s_next.sw_rdata = {13'h0000, s_reg.bac_baud};
        default: s_next.sw_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s_reg <= RESET_STATE;
    else
      s_reg <= s_next;
  end

  // ==========================================================================
  // Outputs
  assign sw_rdata = s_reg.sw_rdata;
  assign lk.req_valid = s_reg.req_valid;
  assign lk.req_bacnet = s_reg.bacnet;
  assign lk.req_node = s_reg.node;
  assign lk.req_func = s_reg.func;
  assign lk.req_addr = s_reg.waddr;
  assign lk.req_data = s_reg.wdata;
  assign line_baud = s_reg.line[rsm_pkg::LINE_BAUD_LSB +: 2];
  assign line_parity = s_reg.line[rsm_pkg::LINE_PAR_LSB +: 2];
  assign line_stop = s_reg.line[rsm_pkg::LINE_STOP_BIT];
  assign bac_baud = s_reg.bac_baud;

endmodule // rsm_master

// >>> verif/rsm_link_chk.sv
// Concurrent checks on the link between the master end and the sensor end
`timescale 1ns/1ps
module rsm_link_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request side
  input wire logic req_valid,
  input wire logic req_bacnet,
  input wire logic [7:0] req_node,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  // Response side
  input wire logic rsp_valid,
  input wire logic rsp_exc,
  input wire logic [7:0] rsp_code,
  input wire logic [15:0] rsp_data
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // Request and answer steps
  sequence s_req(f);
    req_valid && req_func == f;
  endsequence
  sequence s_ok;
    rsp_valid && !rsp_exc;
  endsequence
  sequence s_bad_node;
    req_valid && !req_bacnet && req_func == 8'h06 && req_addr == 16'h0000 &&
      (req_data == 16'h0000 || req_data > 16'h00f7);
  endsequence

  // ==========================================================================
  // Checks
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without a request one cycle before");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe longer than one cycle");
  AST_REQ_SPACING: assert property (req_valid |=> !req_valid [*4])
    else $error("requests closer than one transaction");
  AST_RD_ECHO: assert property (s_req(8'h03) ##1 s_ok |-> rsp_code == 8'h03)
    else $error("holding read not echoed");
  AST_IN_ECHO: assert property (s_req(8'h04) ##1 s_ok |-> rsp_code == 8'h04)
    else $error("input read not echoed");
  AST_WR_ECHO: assert property (s_req(8'h06) ##1 s_ok |-> rsp_data == $past(req_data))
    else $error("single write not echoed");
  AST_BAD_FUNC: assert property (req_valid && !(req_func inside {8'h03, 8'h04, 8'h06}) ##1 rsp_valid
    |-> rsp_exc && rsp_code == 8'h01)
    else $error("unknown function not refused");
  AST_EXC_ZERO: assert property (rsp_valid && rsp_exc |-> rsp_data == 16'h0000)
    else $error("exception carries data");
  AST_NODE_ZERO: assert property (req_valid && !req_bacnet && req_node == 8'h00 |=> !rsp_valid)
    else $error("answer to node zero");
  AST_NODE_RANGE: assert property (s_bad_node ##1 rsp_valid |-> rsp_exc && rsp_code == 8'h03)
    else $error("out of range node accepted");
endmodule // rsm_link_chk

// >>> verif/tb_rs485_sensor_register_map.sv
// Self-checking bench joining the master end and the sensor end over the link
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_rs485_sensor_register_map;
  // Identity values are arbitrary
  localparam logic [127:0] SER = 128'h41424344_45464748_494a4b4c_4d4e4f50;
  int error_cnt = 0;
  int total_checks = 0;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sw_addr = 8'h00;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic [31:0] meas_float [rsm_pkg::NQ];
  logic [31:0] meas_centi [rsm_pkg::NQ];
  logic full_sensor_variant = 1'b1;
  logic heating_on = 1'b0;
  logic cfg_wr = 1'b0;
  logic [1:0] cfg_sel = 2'h0;
  logic [15:0] cfg_data = 16'h0000;
  logic [7:0] node;
  logic [1:0] d_baud, d_par, m_baud, m_par, bac_par;
  logic d_stop, m_stop, bac_stop;
  logic [6:0] bac_node;
  logic [2:0] bac_baud, m_bac;
  rsm_link_if lk ();
  always #4 mclk = ~mclk;
  rsm_device #(.SERIAL_ASCII(SER), .FW_MAJOR(8'h02), .FW_MINOR(8'h07), .SENSOR_NAME(16'h00a5)) u_rsm_device (
    .mclk(mclk), .rst(rst), .lk(lk.device), .meas_float(meas_float), .meas_centi(meas_centi),
    .full_sensor_variant(full_sensor_variant), .heating_on(heating_on), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_data(cfg_data), .bus_node_number(node), .line_baud(d_baud), .line_parity(d_par), .line_stop(d_stop),
    .bac_node(bac_node), .bac_baud(bac_baud), .bac_parity(bac_par), .bac_stop(bac_stop));
  rsm_master u_rsm_master (.mclk(mclk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lk(lk.master), .line_baud(m_baud), .line_parity(m_par),
    .line_stop(m_stop), .bac_baud(m_bac));
  rsm_link_chk u_rsm_link_chk (.mclk(mclk), .rst(rst), .req_valid(lk.req_valid), .req_bacnet(lk.req_bacnet),
    .req_node(lk.req_node), .req_func(lk.req_func), .req_addr(lk.req_addr), .req_data(lk.req_data),
    .rsp_valid(lk.rsp_valid), .rsp_exc(lk.rsp_exc), .rsp_code(lk.rsp_code), .rsp_data(lk.rsp_data));

  // ==========================================================================
  // Software port and transaction helpers
  task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // Kind: 0 answer, 1 exception with code, 2 no answer at all
  task automatic run(input logic bac, input logic [7:0] nd, input logic [7:0] fc, input logic [15:0] rn,
    input logic [15:0] wd, input int kind, input logic [15:0] ev);
    logic [15:0] st;
    logic [15:0] rd;
    sw_write(rsm_pkg::CMD_NODE, {8'h00, nd});
    sw_write(rsm_pkg::CMD_FUNC, {8'h00, fc});
    sw_write(rsm_pkg::CMD_REGNUM, rn);
    sw_write(rsm_pkg::CMD_WDATA, wd);
    sw_write(rsm_pkg::CMD_CTRL, {14'h0000, bac, 1'b1});
    st = 16'h0001;
    for (int i = 0; i < 40 && !(st[0] === 1'b0 && (st[1] === 1'b1 || st[3] === 1'b1)); i++)
      sw_read(rsm_pkg::CMD_STATUS, st);
    sw_read(rsm_pkg::CMD_RDATA, rd);
    `CHK("timeout flag", kind == 2, st[rsm_pkg::ST_TIMEOUT])
    `CHK("done flag", kind != 2, st[rsm_pkg::ST_DONE])
    if (kind != 2)
    begin
      `CHK("exception flag", kind == 1, st[rsm_pkg::ST_EXC])
      `CHK("answer", ev, (kind == 1) ? {8'h00, st[15:8]} : rd)
    end
  endtask

  function automatic logic [15:0] iexp(input int i);
    return 16'(2550 * rsm_pkg::INT_SCALE[i] / 100);
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    `CHK("node", 8'hed, node)
    `CHK("line", 5'h08, {d_stop, d_par, d_baud})
    `CHK("master line", 5'h08, {m_stop, m_par, m_baud})
    `CHK("bac settings", {7'h06, 3'h2, 3'h0}, {bac_node, bac_baud, bac_par, bac_stop})
    `CHK("master bac baud", 3'h2, m_bac)
    run(1'b0, 8'hed, 8'h03, 16'h0001, 16'h0000, 0, 16'h00ed);
    run(1'b0, 8'hed, 8'h03, 16'h0002, 16'h0000, 0, 16'h0008);
    $display("test reset done");
  endtask

  task automatic test_info();
    for (int k = 0; k < 8; k++)
      run(1'b0, 8'hed, 8'h04, 16'(k + 1), 16'h0000, 0, SER[127 - 16 * k -: 16]);
    run(1'b0, 8'hed, 8'h03, 16'h0003, 16'h0000, 0, SER[95:80]);
    run(1'b0, 8'hed, 8'h03, 16'h0009, 16'h0000, 0, 16'h0207);
    run(1'b0, 8'hed, 8'h04, 16'h0009, 16'h0000, 0, 16'h0207);
    run(1'b0, 8'hed, 8'h04, 16'h000a, 16'h0000, 0, 16'h00a5);
    $display("test info done");
  endtask

  task automatic test_meas();
    for (int i = 0; i < rsm_pkg::NQ; i++)
    begin
      run(1'b0, 8'hed, 8'h04, rsm_pkg::FLOAT_ADDR[i] + 16'h1, 16'h0000, 0, meas_float[i][15:0]);
      run(1'b0, 8'hed, 8'h03, rsm_pkg::FLOAT_ADDR[i] + 16'h2, 16'h0000, 0, meas_float[i][31:16]);
      run(1'b0, 8'hed, 8'h04, rsm_pkg::INT_ADDR[i] + 16'h1, 16'h0000, 0, iexp(i));
    end
    @(posedge mclk);
    heating_on <= 1'b1;
    // Heating hides humidity and temperature but not dew point
    for (int i = 4; i < 11; i++)
      run(1'b0, 8'hed, 8'h04, rsm_pkg::INT_ADDR[i] + 16'h1, 16'h0000, (i < 8) ? 1 : 0, (i < 8) ? 16'h0002 : iexp(i));
    @(posedge mclk);
    full_sensor_variant <= 1'b0;
    for (int i = 0; i < rsm_pkg::NQ; i++)
      run(1'b0, 8'hed, 8'h03, rsm_pkg::INT_ADDR[i] + 16'h1, 16'h0000, (i < 2) ? 0 : 1, (i < 2) ? iexp(i) : 16'h0002);
    $display("test meas done");
  endtask

  task automatic test_bac();
    run(1'b1, 8'h06, 8'h03, 16'h0002, 16'h0000, 0, 16'h0002);
    run(1'b1, 8'h06, 8'h06, 16'h0002, 16'h0005, 0, 16'h0005);
    `CHK("bac baud", 3'h5, bac_baud)
    run(1'b1, 8'h06, 8'h06, 16'h0002, 16'h0006, 1, 16'h0003);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_sel <= 2'h3;
    cfg_data <= 16'h0001;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    @(posedge mclk);
    #1 `CHK("vendor bac baud", 3'h1, bac_baud)
    `CHK("bac frame", 3'h0, {bac_par, bac_stop})
    $display("test bac done");
  endtask

  task automatic test_cfg();
    logic [15:0] lw;
    for (int c = 0; c < 18; c++)
    begin
      lw = {11'h000, 1'(c / 9), 2'(c / 3 % 3), 2'(c % 3)};
      run(1'b0, 8'hed, 8'h06, 16'h0002, lw, 0, lw);
      `CHK("line out", lw[4:0], {d_stop, d_par, d_baud})
    end
    run(1'b0, 8'hed, 8'h06, 16'h0002, 16'h000c, 1, 16'h0003);
    sw_write(rsm_pkg::CMD_LINE, 16'h0015);
    @(posedge mclk);
    `CHK("master line", 5'h15, {m_stop, m_par, m_baud})
    run(1'b0, 8'hed, 8'h06, 16'h0001, 16'h00f8, 1, 16'h0003);
    run(1'b0, 8'hed, 8'h06, 16'h0001, 16'h0005, 0, 16'h0005);
    `CHK("new node", 8'h05, node)
    run(1'b0, 8'hed, 8'h03, 16'h0001, 16'h0000, 2, 16'h0000);
    run(1'b0, 8'h00, 8'h03, 16'h0001, 16'h0000, 2, 16'h0000);
    run(1'b0, 8'h05, 8'h03, 16'h0001, 16'h0000, 0, 16'h0005);
    run(1'b0, 8'h05, 8'h10, 16'h0001, 16'h0000, 1, 16'h0001);
    $display("test cfg done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    for (int i = 0; i < rsm_pkg::NQ; i++)
    begin
      meas_float[i] = 32'h44a10b00 + 32'(i);
      meas_centi[i] = 32'd2550;
    end
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 test_reset();
    test_info();
    test_meas();
    test_bac();
    test_cfg();
    stop_test();
  end

  // About 1500 cycles expected; generous margin
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end
endmodule // tb_rs485_sensor_register_map
